// ===== hb16_chk.sv
`default_nettype none
module hb16_chk
  import hb16_pkg::*;
(
  input wire logic ref_clk, nrst, reqValid, reqReady, rspValid, adOe, aleOut, rdStrobeN, wrStrobeN,
  input wire logic [3:0] mainMode, chipSelN,
  input wire logic [1:0] hb16Mode, byteSelCfg, selectLineConfig, byteLaneSelN,
  input wire logic [18:0] reqAddr,
  input wire logic [15:0] adOut,
  input wire logic [2:0] upperAddr
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Taken request; configs 0 and 3 use the latch strobe
  wire logic take = reqValid && reqReady && (mainMode == MAIN_MODE_HB16) && (hb16Mode == HB16_MODE_MUXED);
  wire logic ale = selectLineConfig[0] == selectLineConfig[1];
  ale_cfg_a: assert property (take |=> aleOut == ale) else $error("ale");
  ale_pulse_a: assert property (aleOut |-> $past(take) ##1 !aleOut) else $error("ale");
  addr_out_a: assert property (take |=> adOe && {upperAddr, adOut} == $past(reqAddr)) else $error("adr");
  answer_a: assert property (take |-> ##5 rspValid) else $error("rsp");
  rd_a: assert property ($fell(rdStrobeN) |-> !adOe ##1 !rdStrobeN ##1 rdStrobeN) else $error("rd");
  wr_a: assert property ($fell(wrStrobeN) |-> adOe && $past(adOe, 2) ##2 wrStrobeN) else $error("wr");
  cs_a: assert property (&chipSelN[3:2] && (selectLineConfig != LINE_CFG_ALE || &chipSelN)) else $error("cs");
  gate_a: assert property (!(mainMode == MAIN_MODE_HB16 && hb16Mode == HB16_MODE_MUXED) |=> !reqReady)
    else $error("gate");
  lanes_a: assert property (byteSelCfg == LANE_SEL_OFF |-> &byteLaneSelN) else $error("lanes");
  cover property (take && ale);
  cover property ($fell(rdStrobeN));
  cover property ($fell(wrStrobeN) && !byteLaneSelN[1]);
endmodule
bind host_bus_sixteen hb16_chk chk (.ref_clk, .nrst, .reqValid, .reqReady, .rspValid, .adOe, .aleOut, .rdStrobeN,
  .wrStrobeN, .mainMode, .chipSelN, .hb16Mode, .byteSelCfg, .selectLineConfig, .byteLaneSelN, .reqAddr, .adOut,
  .upperAddr);
`default_nettype wire

// ===== hb16_peer.sv
`default_nettype none
module hb16_peer (
  input wire logic ref_clk, lanesOn, aleOut, rdStrobeN, wrStrobeN,
  input wire logic [3:0] chipSelN,
  input wire logic [1:0] byteLaneSelN,
  input wire logic [15:0] adOut,
  output logic [15:0] adIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [16], junk = 16'h5A3C;
  logic [3:0] slot, csQ = 4'hF;
  always @(posedge ref_clk) begin
    csQ <= chipSelN;
    junk <= ~junk;
    if (aleOut || |(csQ & ~chipSelN)) slot <= adOut[3:0];
    if (!wrStrobeN && (!lanesOn || !byteLaneSelN[0])) mem[slot][7:0] <= adOut[7:0];
    if (!wrStrobeN && (!lanesOn || !byteLaneSelN[1])) mem[slot][15:8] <= adOut[15:8];
  end
  assign adIn = rdStrobeN ? junk : mem[slot];
endmodule
`default_nettype wire

// ===== hb16_pkg.sv
`default_nettype none
package hb16_pkg;
  // ----------------------------------------
  // Configuration encodings
  // ----------------------------------------
  localparam logic [3:0] MAIN_MODE_HB16 = 4'h3;
  localparam logic [1:0] HB16_MODE_MUXED = 2'h0;
  localparam logic [1:0] LANE_SEL_OFF = 2'h1;
  localparam logic [1:0] LINE_CFG_ALE = 2'h0;
  localparam logic [1:0] LINE_CFG_ONE_CS = 2'h1;
  localparam logic [1:0] LINE_CFG_TWO_CS = 2'h2;
  localparam logic [1:0] LINE_CFG_ALE_TWO_CS = 2'h3;
  // ----------------------------------------
  // Reset values and phase counts
  // ----------------------------------------
  localparam logic [15:0] AD_RESET = 16'h0000;
  localparam logic [3:0] ADDR_CYCLES = 4'h2;
  localparam logic [3:0] DATA_CYCLES = 4'h2;
  // ----------------------------------------
  // Access phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } phase_t;
endpackage
`default_nettype wire

// ===== hb16_strobe_timer.sv
`default_nettype none
module hb16_strobe_timer
  import hb16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [3:0] loadValue,
  output logic expired
);
  // ----------------------------------------
  // Phase countdown
  // ----------------------------------------
  logic [3:0] cnt_q; // Remaining cycles
  logic [3:0] cnt_d;
  // Next count
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = loadValue - 4'h1;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end
  // Register count
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // Expires when count is zero; load is left out so the caller may reload on expiry without a loop
  assign expired = (cnt_q == 4'h0);
endmodule
`default_nettype wire

// ===== host_bus_sixteen.sv
`default_nettype none
module host_bus_sixteen
  import hb16_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] mainMode,
  input wire logic [1:0] hb16Mode,
  input wire logic [1:0] byteSelCfg,
  input wire logic [1:0] selectLineConfig,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [18:0] reqAddr,
  input wire logic [15:0] reqWdata,
  input wire logic [1:0] reqLanes,
  input wire logic [1:0] reqChip,
  input wire logic [15:0] adIn,
  output logic reqReady,
  output logic rspValid,
  output logic [15:0] rspRdata,
  output logic [15:0] adOut,
  output logic adOe,
  output logic [2:0] upperAddr,
  output logic aleOut,
  output logic rdStrobeN,
  output logic wrStrobeN,
  output logic [3:0] chipSelN,
  output logic [1:0] byteLaneSelN,
  output logic active
);
  // ----------------------------------------
  // Personality decode
  // ----------------------------------------
  logic enabled; // Port in muxed sixteen-bit mode
  // Main and sub mode both select this form
  assign enabled = (mainMode == MAIN_MODE_HB16) && (hb16Mode == HB16_MODE_MUXED);
  logic useAle; // Config uses latch strobe
  assign useAle = (selectLineConfig == LINE_CFG_ALE) || (selectLineConfig == LINE_CFG_ALE_TWO_CS);

  // ----------------------------------------
  // State
  // ----------------------------------------
  phase_t st_q, st_d; // Access phase
  logic write_q, write_d; // Latched direction
  logic [18:0] addr_q, addr_d; // Latched address
  logic [15:0] wdata_q, wdata_d; // Latched write data
  logic [1:0] lanes_q, lanes_d; // Latched lanes
  logic [1:0] chip_q, chip_d; // Latched chip index
  logic [15:0] rdata_q, rdata_d; // Captured read data
  logic rspValid_q, rspValid_d; // Answer pulse
  logic [15:0] adOut_q, adOut_d; // Mux line drive
  logic adOe_q, adOe_d; // Mux line enable
  logic [2:0] upper_q, upper_d; // Upper address lines
  logic ale_q, ale_d; // Latch strobe
  logic rdN_q, rdN_d; // Read strobe
  logic wrN_q, wrN_d; // Write strobe
  logic [3:0] csN_q, csN_d; // Chip selects
  logic [1:0] blN_q, blN_d; // Byte-lane selects
  logic timerLoad; // Start a phase
  logic [3:0] timerValue; // Phase length
  logic timerDone; // Phase over
  logic ready_q; // Taking requests, registered
  logic active_q; // Busy, registered

  // ----------------------------------------
  // Phase timer
  // ----------------------------------------
  hb16_strobe_timer timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(timerLoad),
    .loadValue(timerValue),
    .expired(timerDone)
  );

  // ----------------------------------------
  // Chip select decode
  // ----------------------------------------
  logic [3:0] csSel; // Active-high selects for this access
  always_comb begin
    csSel = 4'h0;
    // Select option decode
    // option field decode
    case (selectLineConfig)
      LINE_CFG_ALE: csSel = 4'h0;
      LINE_CFG_ONE_CS: csSel = 4'h1;
      LINE_CFG_TWO_CS, LINE_CFG_ALE_TWO_CS: csSel = chip_q[0] ? 4'h2 : 4'h1;
      default: csSel = 4'h0;
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    write_d = write_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    lanes_d = lanes_q;
    chip_d = chip_q;
    rdata_d = rdata_q;
    rspValid_d = 1'b0;
    adOut_d = adOut_q;
    adOe_d = adOe_q;
    upper_d = upper_q;
    ale_d = 1'b0;
    rdN_d = 1'b1;
    wrN_d = 1'b1;
    csN_d = 4'hF;
    blN_d = 2'h3;
    timerLoad = 1'b0;
    timerValue = ADDR_CYCLES;
    case (st_q)
      // Wait for a request
      ST_IDLE: begin
        adOe_d = 1'b0;
        // accept only in mode
        // Ready gates the take, so no request slips in on the first edge after reset
        if (reqValid && enabled && ready_q) begin
          write_d = reqWrite;
          addr_d = reqAddr;
          wdata_d = reqWdata;
          lanes_d = reqLanes;
          chip_d = reqChip;
          adOut_d = reqAddr[15:0];
          adOe_d = 1'b1;
          upper_d = reqAddr[18:16];
          ale_d = useAle;
          timerLoad = 1'b1;
          timerValue = ADDR_CYCLES;
          st_d = ST_ADDR;
        end
      end
      // Address held on the lines
      ST_ADDR: begin
        csN_d = ~csSel;
        if (timerDone) begin
          adOut_d = wdata_q;
          adOe_d = write_q;
          timerLoad = 1'b1;
          timerValue = DATA_CYCLES;
          st_d = ST_DATA;
          rdN_d = write_q;
          wrN_d = !write_q;
          blN_d = (byteSelCfg == LANE_SEL_OFF) ? 2'h3 : ~lanes_q;
        end
      end
      // Strobe asserted, data on lines
      ST_DATA: begin
        csN_d = ~csSel;
        blN_d = blN_q;
        rdN_d = rdN_q;
        wrN_d = wrN_q;
        if (timerDone) begin
          rdN_d = 1'b1;
          wrN_d = 1'b1;
          blN_d = 2'h3;
          // Read data sampled at strobe end
          if (!write_q) begin
            rdata_d = adIn;
          end
          rspValid_d = 1'b1;
          st_d = ST_DONE;
        end
      end
      // Release lines, one recovery cycle
      ST_DONE: begin
        adOe_d = 1'b0;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      write_q <= 1'b0;
      addr_q <= 19'h00000;
      wdata_q <= AD_RESET;
      lanes_q <= 2'h0;
      chip_q <= 2'h0;
      rdata_q <= AD_RESET;
      rspValid_q <= 1'b0;
      adOut_q <= AD_RESET;
      adOe_q <= 1'b0;
      upper_q <= 3'h0;
      ale_q <= 1'b0;
      rdN_q <= 1'b1;
      wrN_q <= 1'b1;
      csN_q <= 4'hF;
      blN_q <= 2'h3;
    end else begin
      st_q <= st_d;
      write_q <= write_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      lanes_q <= lanes_d;
      chip_q <= chip_d;
      rdata_q <= rdata_d;
      rspValid_q <= rspValid_d;
      adOut_q <= adOut_d;
      adOe_q <= adOe_d;
      upper_q <= upper_d;
      ale_q <= ale_d;
      rdN_q <= rdN_d;
      wrN_q <= wrN_d;
      csN_q <= csN_d;
      blN_q <= blN_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ready and busy flags, both registered
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ready_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      ready_q <= (st_d == ST_IDLE) && enabled;
      active_q <= (st_d != ST_IDLE);
    end
  end
  assign reqReady = ready_q;
  assign rspValid = rspValid_q;
  assign rspRdata = rdata_q;
  assign adOut = adOut_q;
  assign adOe = adOe_q;
  assign upperAddr = upper_q;
  assign aleOut = ale_q;
  assign rdStrobeN = rdN_q;
  assign wrStrobeN = wrN_q;
  assign chipSelN = csN_q;
  assign byteLaneSelN = blN_q;
  assign active = active_q;
endmodule
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hb16_pkg::*;
  logic ref_clk = 1'h0, nrst = 1'h0, reqValid = 1'h0, reqWrite = 1'h0;
  logic reqReady, rspValid, adOe, aleOut, rdStrobeN, wrStrobeN, active;
  logic [3:0] mainMode = MAIN_MODE_HB16, chipSelN, s;
  logic [1:0] hb16Mode = HB16_MODE_MUXED, byteSelCfg = LANE_SEL_OFF, selectLineConfig = 2'h0;
  logic [1:0] reqLanes = 2'h3, reqChip = 2'h0, byteLaneSelN, ln;
  logic [18:0] reqAddr = 19'h0;
  logic [15:0] reqWdata = 16'h0, adIn, adOut, rspRdata, shadow [16];
  logic [2:0] upperAddr;
  logic [20:0] notes [$], note;
  int mismatches = 0, n_compared = 0, seed = 73, n;
  host_bus_sixteen dut (.ref_clk, .nrst, .mainMode, .hb16Mode, .byteSelCfg, .selectLineConfig, .reqValid, .reqWrite,
    .reqAddr, .reqWdata, .reqLanes, .reqChip, .adIn, .reqReady, .rspValid, .rspRdata, .adOut, .adOe, .upperAddr,
    .aleOut, .rdStrobeN, .wrStrobeN, .chipSelN, .byteLaneSelN, .active(active));
  hb16_peer peer (.ref_clk, .lanesOn(byteSelCfg != LANE_SEL_OFF), .aleOut, .rdStrobeN, .wrStrobeN, .chipSelN,
    .byteLaneSelN, .adOut, .adIn);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One access from a falling edge; request stays raised once taken
  task automatic acc(input logic wr, input logic [3:0] slot);
    ln = 2'($random(seed));
    if (ln == 2'h0) ln = 2'h2;
    {reqWrite, reqAddr, reqWdata, reqChip} = {wr, 15'($random(seed)), slot, 16'($random(seed)), 2'($random(seed))};
    reqLanes = ln;
    reqValid = 1'h1;
    if (byteSelCfg == LANE_SEL_OFF) ln = 2'h3;
    n = 0;
    do @(posedge ref_clk); while (reqReady !== 1'h1 && ++n < 40);
    if (reqReady !== 1'h1) begin
      mismatches++;
      give_verdict();
    end
    if (wr && ln[0]) shadow[slot][7:0] = reqWdata[7:0];
    if (wr && ln[1]) shadow[slot][15:8] = reqWdata[15:8];
    notes.push_back({wr, slot, shadow[slot]});
    @(negedge ref_clk);
    chk(16'(active), 16'h1);
  endtask
  // Each result takes the oldest note
  always @(negedge ref_clk) begin
    if (rspValid === 1'h1) begin
      if (notes.size() == 0) chk(rspRdata, ~rspRdata);
      else begin
        note = notes.pop_front();
        if (note[20]) chk(peer.mem[note[19:16]], note[15:0]);
        else chk(rspRdata, note[15:0]);
      end
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'h1;
    for (int i = 0; i < 16; i++) acc(1'h1, 4'(i));
    $display("test fill done");
    for (int c = 0; c < 8; c++) begin
      reqValid = 1'h0;
      repeat (10) @(negedge ref_clk);
      {byteSelCfg, selectLineConfig} = {c[2] ? 2'h2 : LANE_SEL_OFF, 2'(c)};
      repeat (3) begin
        s = 4'($random(seed));
        acc(1'h1, s);
        acc(1'h0, s);
        acc(1'h0, 4'($random(seed)));
      end
      $display("test cfg %0d lanes %0d done", selectLineConfig, byteSelCfg);
    end
    reqValid = 1'h0;
    repeat (10) @(negedge ref_clk);
    chk(16'(notes.size()), 16'h0);
    // Requests under another mode are ignored
    {mainMode, reqValid} = {4'h0, 1'h1};
    repeat (12) begin
      @(negedge ref_clk);
      chk(16'({active, reqReady}), 16'h0);
    end
    {mainMode, hb16Mode} = {MAIN_MODE_HB16, 2'h1};
    repeat (12) begin
      @(negedge ref_clk);
      chk(16'({active, reqReady}), 16'h0);
    end
    {hb16Mode, reqValid} = {HB16_MODE_MUXED, 1'h0};
    $display("test disabled done");
    give_verdict();
  end
endmodule
`default_nettype wire
